// [core/vps_bip8.sv]
/*
 * Even bit-interleaved parity over every outgoing byte of one frame.
 * Assumes byte_en marks each outgoing byte and frame_first its first byte.
 */
`timescale 1ns/10ps
module vps_bip8 (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       byte_en,
   input  wire logic       frame_first,
   input  wire logic [7:0] byte_out,
   output logic      [7:0] parity_prev
);

   logic [7:0] acc_q;

   // -----------------------------------------------------------------
   // Running parity, closed at every frame boundary
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_q       <= vps_pkg::DATA_RST;
         parity_prev <= vps_pkg::DATA_RST;
      end else if (byte_en) begin
         if (frame_first) begin
            parity_prev <= acc_q;
            acc_q       <= byte_out;
         end else begin
            acc_q <= acc_q ^ byte_out;
         end
      end
   end

endmodule : vps_bip8

// [core/vps_source.sv]
/*
 * Path overhead source: inserts trace, parity and remote status bytes
 * into the adapted container stream and forwards clock and frame start.
 * Assumes all stream and remote inputs are asynchronous pins, the trace
 * identifier comes from management logic on sys_clk, and sys_clk runs
 * well above four times the adapted byte clock.
 */
`timescale 1ns/10ps

module vps_source #(
   parameter int unsigned TRACE_BYTES   = vps_pkg::TRACE_BYTES,
   parameter int unsigned REMOTE_MAX_CYC = vps_pkg::REMOTE_MAX_CYC
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   input  wire logic [7:0]               adapted_data_in,
   input  wire logic                     adapted_clock_in,
   input  wire logic                     adapted_frame_start_in,
   input  wire logic                     remote_defect_request,
   input  wire logic [3:0]               remote_error_count,
   input  wire logic [TRACE_BYTES*8-1:0] transmit_trace_id,
   output logic      [7:0]               path_data_out,
   output logic                          path_clock_out,
   output logic                          path_frame_start_out
);

   // -----------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------
   function automatic logic [3:0] rei_code(input logic [3:0] cnt);
      // Counts above eight can reach the 4-bit port; clamp rather than wrap
      if (cnt > vps_pkg::REI_MAX) begin
         rei_code = vps_pkg::REI_MAX;
      end else begin
         rei_code = cnt;
      end
   endfunction : rei_code

   function automatic logic [7:0] status_byte(input logic [3:0] rei,
                                              input logic       rdi);
      status_byte = {rei_code(rei), rdi, vps_pkg::G1_SPARE,
                     vps_pkg::G1_LSB};
   endfunction : status_byte

   function automatic logic [7:0] trace_byte(
      input logic [TRACE_BYTES*8-1:0] id,
      input logic [3:0]               idx);
      logic [TRACE_BYTES*8-1:0] sh;
      sh = id << (32'(idx) * 8);
      trace_byte = sh[TRACE_BYTES*8-1 -: 8];
   endfunction : trace_byte

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   localparam int unsigned SW = 15;

   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic          clk_d3_q;
   logic [3:0]    rei_d3_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {adapted_clock_in, adapted_frame_start_in,
                     adapted_data_in, remote_defect_request,
                     remote_error_count};
         sync2_q <= sync1_q;
      end
   end

   logic       clk_s;
   logic       fs_s;
   logic [7:0] data_s;
   logic       rdi_s;
   logic [3:0] rei_s;

   assign clk_s  = sync2_q[14];
   assign fs_s   = sync2_q[13];
   assign data_s = sync2_q[12:5];
   assign rdi_s  = sync2_q[4];
   assign rei_s  = sync2_q[3:0];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_d3_q <= 1'b0;
      end else begin
         clk_d3_q <= clk_s;
      end
   end

   // Extra stage on the count, only to tell a settled word from a moving one
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rei_d3_q <= 4'h0;
      end else begin
         rei_d3_q <= rei_s;
      end
   end

   // One-cycle enable per adapted byte, taken on its rising clock edge
   logic byte_en;
   assign byte_en = clk_s & ~clk_d3_q;

   // -----------------------------------------------------------------
   // Frame position
   // -----------------------------------------------------------------
   logic [3:0] row_q;
   logic [6:0] col_q;
   logic [3:0] row_cur;
   logic [6:0] col_cur;

   // Frame start wins over the counters, so alignment recovers in a frame
   assign row_cur = fs_s ? vps_pkg::ROW_TRACE : row_q;
   assign col_cur = fs_s ? vps_pkg::COL_OVH   : col_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         row_q <= vps_pkg::ROW_TRACE;
         col_q <= vps_pkg::COL_OVH;
      end else if (byte_en) begin
         if (col_cur == vps_pkg::COL_LAST) begin
            col_q <= vps_pkg::COL_OVH;
            row_q <= (row_cur == vps_pkg::ROW_LAST) ?
                     vps_pkg::ROW_TRACE : row_cur + 4'h1;
         end else begin
            col_q <= col_cur + 7'h01;
            row_q <= row_cur;
         end
      end
   end

   // -----------------------------------------------------------------
   // Trace index, one byte of the identifier per frame
   // -----------------------------------------------------------------
   logic [3:0] trace_idx_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trace_idx_q <= vps_pkg::IDX_RST;
      end else if (byte_en && fs_s) begin
         if (32'(trace_idx_q) == TRACE_BYTES - 1) begin
            trace_idx_q <= vps_pkg::IDX_RST;
         end else begin
            trace_idx_q <= trace_idx_q + 4'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Remote status snapshot
   // -----------------------------------------------------------------
   // Defect bit refreshed every frame (125 us), error count in the next frame it is settled at frame start, far inside the REMOTE_MAX_CYC bound
   logic [3:0] rei_q;
   logic       rdi_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rei_q <= 4'h0;
         rdi_q <= 1'b0;
      end else if (byte_en && fs_s) begin
         rdi_q <= rdi_s;
         // Bits settle unevenly; a word seen changing waits one frame
         if (rei_s == rei_d3_q) begin
            rei_q <= rei_s;
         end
      end
   end

   // -----------------------------------------------------------------
   // Overhead insertion
   // -----------------------------------------------------------------
   logic [7:0] parity_prev;
   logic [7:0] out_d;
   logic       is_ovh;

   assign is_ovh = (col_cur == vps_pkg::COL_OVH);

   always_comb begin
      out_d = data_s;
      if (is_ovh) begin
         case (row_cur)
            vps_pkg::ROW_TRACE:
               out_d = trace_byte(transmit_trace_id, trace_idx_q);
            vps_pkg::ROW_PARITY:
               out_d = parity_prev;
            vps_pkg::ROW_STATUS:
               out_d = status_byte(rei_q, rdi_q);
            default:
               out_d = data_s;
         endcase
      end
   end

   vps_bip8 u_bip8 (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .byte_en     (byte_en),
      .frame_first (fs_s),
      .byte_out    (out_d),
      .parity_prev (parity_prev)
   );

   // -----------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------
   // Clock lags data by one cycle so data is settled at its rising edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         path_data_out        <= vps_pkg::DATA_RST;
         path_frame_start_out <= 1'b0;
      end else if (byte_en) begin
         path_data_out        <= out_d;
         path_frame_start_out <= fs_s;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         path_clock_out <= 1'b0;
      end else begin
         path_clock_out <= clk_d3_q;
      end
   end

endmodule : vps_source

// [shared/vps_pkg.sv]
/*
 * Constants shared by the path overhead source and its parity helper.
 * Assumes the adapted stream is a byte-wide container of 9 rows by 85
 * columns, with the overhead column first and frame start on its first byte.
 */
package vps_pkg;

   // -----------------------------------------------------------------
   // Frame geometry
   // -----------------------------------------------------------------
   localparam int unsigned ROWS        = 9;
   localparam int unsigned COLS        = 85;
   localparam logic [3:0]  ROW_LAST    = 4'h8;
   localparam logic [6:0]  COL_LAST    = 7'h54;
   localparam logic [3:0]  ROW_TRACE   = 4'h0;
   localparam logic [3:0]  ROW_PARITY  = 4'h1;
   localparam logic [3:0]  ROW_STATUS  = 4'h3;
   localparam logic [6:0]  COL_OVH     = 7'h00;

   // -----------------------------------------------------------------
   // Trace identifier and status byte layout
   // -----------------------------------------------------------------
   localparam int unsigned TRACE_BYTES = 16;
   localparam logic [3:0]  REI_MAX     = 4'h8;
   localparam logic [1:0]  G1_SPARE    = 2'h0;
   localparam logic        G1_LSB      = 1'b0;
   localparam int unsigned G1_REI_POS  = 4;
   localparam int unsigned G1_RDI_POS  = 3;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned REMOTE_MAX_US = 1000;
   localparam int unsigned REMOTE_MAX_CYC = REMOTE_MAX_US * CLK_MHZ;
   localparam int unsigned SYNC_STAGES   = 2;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0]  DATA_RST    = 8'h00;
   localparam logic [3:0]  IDX_RST     = 4'h0;

endpackage : vps_pkg

// [test/tb_vps_source.sv]
/* Bench for the path overhead source with a byte-level reference model.
   Assumes the adaptation model above and the bound port checker. */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_vps_source;
   logic         sys_clk, rst, rdi, rdi_s, cin, fsi, cout, fso;
   logic [3:0]   rei, rei_s;
   logic [127:0] tid;
   logic [7:0]   din, dout, acc, prev, ev, v;
   logic [7:0]   eq[$];
   int           iq[$];
   int           byte_idx, ei, cyc, fr, nfr, errors, check_count;
   int           seed = 54;
   vps_source dut (.sys_clk(sys_clk), .rst(rst), .adapted_data_in(din),
      .adapted_clock_in(cin), .adapted_frame_start_in(fsi),
      .remote_defect_request(rdi), .remote_error_count(rei),
      .transmit_trace_id(tid), .path_data_out(dout),
      .path_clock_out(cout), .path_frame_start_out(fso));
   vps_adapt_model u_src (.sys_clk(sys_clk), .rst(rst),
      .adapted_data_in(din), .adapted_clock_in(cin),
      .adapted_frame_start_in(fsi), .byte_idx(byte_idx));
   // ---------------------------------------------
   // Reference model
   // ---------------------------------------------
   always @(posedge cin) begin
      v = din;
      if (byte_idx == 0) begin
         prev = acc;
         acc = 8'h00;
         rei_s = (rei > 4'h8) ? 4'h8 : rei;
         rdi_s = rdi;
         v = tid[127-8*fr -: 8];
         fr = (fr + 1) % 16;
         nfr++;
      end
      if (byte_idx == 85) v = prev;
      if (byte_idx == 255) v = {rei_s, rdi_s, 3'b000};
      acc ^= v;
      eq.push_back(v);
      // First parity after reset carries no meaning
      iq.push_back((byte_idx == 85 && nfr == 1) ? 999 : byte_idx);
   end
   always @(negedge cin) if (byte_idx == 400) begin
      rei = 4'($random(seed));
      rdi = 1'($random(seed));
   end
   always @(posedge cout) begin
      if (eq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
         ev = eq.pop_front();
         ei = iq.pop_front();
         `CHK(fso, 1'(ei == 0))
         if (ei == 0) `CHK(dout, ev)
         else if (ei == 85) `CHK(dout, ev)
         else if (ei == 255) `CHK(dout, ev)
         else if (ei != 999) `CHK(dout, ev)
      end
   end
   // ---------------------------------------------
   // Sequence and verdict
   // ---------------------------------------------
   task automatic stop_test();
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 50000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      rst = 1'b1;
      // Undefined first parity still feeds the second frame's parity
      acc = vps_pkg::DATA_RST;
      prev = vps_pkg::DATA_RST;
      rei = 4'h8;
      rdi = 1'b1;
      tid = {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      wait (check_count >= 6000);
      stop_test();
   end
endmodule : tb_vps_source

// [test/vps_adapt_model.sv]
/* Adaptation side: byte clock of 12 sys_clk, random bytes, frame start.
   Assumes sys_clk at 200 MHz; data moves only while the clock is low. */
`timescale 1ns/10ps
module vps_adapt_model (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   output logic      [7:0] adapted_data_in,
   output logic            adapted_clock_in,
   output logic            adapted_frame_start_in,
   output int              byte_idx
);
   int seed = 54;
   int ph;
   always @(posedge sys_clk) begin
      #1;
      if (rst) begin
         ph = 0;
         byte_idx = 0;
         adapted_clock_in = 1'b0;
         adapted_frame_start_in = 1'b1;
         adapted_data_in = 8'h00;
      end else begin
         ph = (ph + 1) % 12;
         if (ph == 6) adapted_clock_in = 1'b1;
         if (ph == 0) begin
            // Change at the fall: six cycles of margin either side
            adapted_clock_in = 1'b0;
            byte_idx = (byte_idx + 1) % 765;
            adapted_frame_start_in = (byte_idx == 0);
            adapted_data_in = 8'($random(seed));
         end
      end
   end
endmodule : vps_adapt_model

// [test/vps_source_sva.sv]
/* Port checker for the path overhead source.
   Assumes remote inputs stay steady from frame start until G1 leaves. */
`timescale 1ns/10ps
module vps_chk #(parameter int unsigned TRACE_BYTES = 16) (
   input wire logic                     sys_clk,
   input wire logic                     rst,
   input wire logic [7:0]               adapted_data_in,
   input wire logic                     adapted_clock_in,
   input wire logic                     adapted_frame_start_in,
   input wire logic                     remote_defect_request,
   input wire logic [3:0]               remote_error_count,
   input wire logic [TRACE_BYTES*8-1:0] transmit_trace_id,
   input wire logic [7:0]               path_data_out,
   input wire logic                     path_clock_out,
   input wire logic                     path_frame_start_out
);
   // ---------------------------------------------
   // Byte position tracking
   // ---------------------------------------------
   logic [9:0] idx_q;
   logic [9:0] nxt;
   logic [3:0] fr_q;
   logic [7:0] din_q;
   assign nxt = path_frame_start_out ? 10'h000 : idx_q + 10'h001;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idx_q <= 10'h000;
         fr_q  <= 4'h0;
         din_q <= 8'h00;
      end else begin
         if ($rose(adapted_clock_in)) din_q <= adapted_data_in;
         if ($rose(path_clock_out)) idx_q <= nxt;
         if ($rose(path_clock_out) && nxt == 10'h000) fr_q <= fr_q + 4'h1;
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_up;  $rose(path_clock_out); endsequence
   sequence s_g1;  s_up ##0 (nxt == 10'h0ff); endsequence
   property p_clk_up; $rose(adapted_clock_in) |-> ##[3:6] s_up; endproperty
   property p_clk_dn;
      $fell(adapted_clock_in) |-> ##[3:6] $fell(path_clock_out);
   endproperty
   property p_fs;
      $rose(adapted_clock_in) && adapted_frame_start_in
         |-> ##[2:5] path_frame_start_out;
   endproperty
   property p_hold; s_up |-> $stable(path_data_out) [*4]; endproperty
   property p_pass;
      s_up ##0 !(nxt inside {10'h000, 10'h055, 10'h0ff})
         |-> path_data_out == din_q;
   endproperty
   property p_j1;
      s_up ##0 (nxt == 10'h000) |-> path_data_out ==
         transmit_trace_id[TRACE_BYTES*8-1-8*fr_q -: 8];
   endproperty
   property p_rei;
      s_g1 |-> path_data_out[7:4] == (remote_error_count > vps_pkg::REI_MAX
         ? vps_pkg::REI_MAX : remote_error_count);
   endproperty
   property p_rdi; s_g1 |-> path_data_out[3] == remote_defect_request;
   endproperty
   property p_spare; s_g1 |-> path_data_out[2] == path_data_out[1];
   endproperty
   a_clk_up: assert property (p_clk_up) else $error("clock out late");
   a_clk_dn: assert property (p_clk_dn) else $error("clock low late");
   a_fs: assert property (p_fs) else $error("frame start lost");
   a_hold: assert property (p_hold) else $error("byte unstable");
   a_pass: assert property (p_pass) else $error("payload altered");
   a_j1: assert property (p_j1) else $error("trace byte wrong");
   a_rei: assert property (p_rei) else $error("error count wrong");
   a_rdi: assert property (p_rdi) else $error("defect bit wrong");
   a_spare: assert property (p_spare) else $error("mixed spare bits");
endmodule : vps_chk
bind vps_source vps_chk #(.TRACE_BYTES(TRACE_BYTES)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .adapted_data_in(adapted_data_in),
   .adapted_clock_in(adapted_clock_in),
   .adapted_frame_start_in(adapted_frame_start_in),
   .remote_defect_request(remote_defect_request),
   .remote_error_count(remote_error_count),
   .transmit_trace_id(transmit_trace_id), .path_data_out(path_data_out),
   .path_clock_out(path_clock_out),
   .path_frame_start_out(path_frame_start_out));
